/* rtl/gdpsa_pkg.sv */
package gdpsa_pkg;

   // ----------------------------------------
   // register map (4-bit register address)
   // ----------------------------------------
   localparam int          ADDR_W      = 4;
   localparam int          DATA_W      = 8;
   localparam logic [3:0]  REG_FUNC    = 4'hC;   // pin_function_select
   localparam logic [3:0]  REG_DIR     = 4'hD;   // pin_direction_bits
   localparam logic [3:0]  REG_LEVEL   = 4'hE;   // port_pin_levels
   localparam logic [7:0]  REG_RESET   = 8'h00;  // all three clear at reset

   // ----------------------------------------
   // command byte layout
   // ----------------------------------------
   localparam int          CMD_RD_BIT  = 7;      // 1 = read, 0 = write
   localparam int          CMD_ADDR_LO = 0;
   localparam logic [2:0]  BIT_LAST    = 3'h7;   // last bit of a byte

   // ----------------------------------------
   // pin positions on the shared port
   // ----------------------------------------
   localparam int          PIN_POS_REF_ZERO = 0; // pos_reference_pin_zero
   localparam int          PIN_NEG_REF_ZERO = 1; // neg_reference_pin_zero
   localparam int          PIN_AIN_LO       = 2; // analog_input_two..seven

   // ----------------------------------------
   // synchroniser lane layout
   // ----------------------------------------
   localparam int          SY_SCLK = 8;
   localparam int          SY_SEL  = 9;
   localparam int          SY_MOSI = 10;
   localparam int          SY_W    = 11;

   // ----------------------------------------
   // host power-on hold-off, master clocks
   // ----------------------------------------
   localparam int          POR_MCLK_CYCLES = 216;

   // frame phase
   typedef enum logic [1:0] {
      PH_CMD  = 2'b00,
      PH_DATA = 2'b01,
      PH_DONE = 2'b10
   } gdpsa_phase_t;

endpackage

/* rtl/gdpsa_sync.sv */
`timescale 1ns/1ps
module gdpsa_sync #(
   parameter int W = 11
) (
   // clock and reset
   input  wire logic         ref_clk,
   input  wire logic         reset,
   // raw asynchronous levels
   input  wire logic [W-1:0] async_in,
   // filtered levels
   output logic      [W-1:0] level
);

   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      logic [W-1:0] s1;   // first stage, read only by s2
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] lvl;  // last accepted level, held while stages disagree
   } gdpsa_sync_t;

   gdpsa_sync_t  st_q;
   gdpsa_sync_t  st_d;
   logic [W-1:0] agree;    // lanes whose stages two and three match
   logic [W-1:0] lvl_now;  // accepted level, built from flops only

   // a lane moves as soon as stages two and three agree; waiting for the
   // registered copy would cost a cycle and push read data past the
   // host's capturing edge at the fastest serial clock
   assign agree   = ~(st_q.s2 ^ st_q.s3);
   assign lvl_now = (st_q.s2 & agree) | (st_q.lvl & ~agree);

   // shift chain plus the held level
   always_comb begin
      st_d     = st_q;
      st_d.s1  = async_in;
      st_d.s2  = st_q.s1;
      st_d.s3  = st_q.s2;
      st_d.lvl = lvl_now;
   end

   // register the whole state
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign level = lvl_now;

endmodule

/* rtl/gdpsa_top.sv */
//Operation
// - output pins driven from stored level bits
// - input pins read back their live level
// - writes only store bits, inputs unaffected
// - zero is low, one high; reset clears
// - bits 7..2 analog, 1 neg, 0 pos reference
// - serial mode 1, clock idles low
// - serial data changes on rising clock edge
// - serial data captured on falling clock edge
// - function select bit: 1 digital, 0 analog
// - direction bit: 0 output, 1 input
// - level register sits at offset 0Eh
`timescale 1ns/1ps
module gdpsa_top (
   // clock and reset
   input  wire logic       ref_clk,
   input  wire logic       reset,
   // serial register port
   input  wire logic       sclk,
   input  wire logic       cs_n,
   input  wire logic       mosi,
   output logic            miso,
   output logic            miso_oe,
   // shared port pins
   input  wire logic [7:0] pin_in,
   output logic      [7:0] pin_out,
   output logic      [7:0] pin_oe
);

   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      logic [7:0]            func;      // pin_function_select
      logic [7:0]            dir;       // pin_direction_bits
      logic [7:0]            level;     // pin_level_bits
      logic [7:0]            shift;     // receive shifter
      logic [7:0]            tx;        // transmit shifter
      logic [7:0]            cmd;       // latched command byte
      logic [2:0]            bitcnt;    // bit within byte
      gdpsa_pkg::gdpsa_phase_t phase;
      logic                  sclk_prev; // for edge finding
      logic                  miso;
      logic                  miso_oe;
      logic [7:0]            pin_out;
      logic [7:0]            pin_oe;
   } gdpsa_state_t;

   gdpsa_state_t st_q;
   gdpsa_state_t st_d;

   // ----------------------------------------
   // input synchronisers
   // ----------------------------------------
   logic [gdpsa_pkg::SY_W-1:0] sy;       // filtered inputs

   // chip select inverted first so the reset value means idle
   gdpsa_sync #(
      .W (gdpsa_pkg::SY_W)
   ) u_sync (
      .ref_clk  (ref_clk),
      .reset    (reset),
      .async_in ({mosi, ~cs_n, sclk, pin_in}),
      .level    (sy)
   );

   logic       sclk_lvl;   // filtered serial clock
   logic       sel;        // frame active
   logic       mosi_lvl;   // filtered serial data in
   logic [7:0] pin_lvl;    // filtered pin levels
   logic       rise;       // serial clock rising
   logic       fall;       // serial clock falling
   logic       byte_end;   // last falling edge of a byte
   logic [7:0] rx_byte;    // byte completed this cycle
   logic [3:0] cmd_addr;   // latched register address
   logic       wr_level;   // write strobe to level register

   assign sclk_lvl = sy[gdpsa_pkg::SY_SCLK];
   assign sel      = sy[gdpsa_pkg::SY_SEL];
   assign mosi_lvl = sy[gdpsa_pkg::SY_MOSI];
   assign pin_lvl  = sy[7:0];
   assign rise     = sclk_lvl & ~st_q.sclk_prev;
   assign fall     = ~sclk_lvl & st_q.sclk_prev;
   assign byte_end = sel & fall & (st_q.bitcnt == gdpsa_pkg::BIT_LAST);
   assign rx_byte  = {st_q.shift[6:0], mosi_lvl};
   assign cmd_addr = st_q.cmd[gdpsa_pkg::CMD_ADDR_LO +: gdpsa_pkg::ADDR_W];
   assign wr_level = byte_end && (st_q.phase == gdpsa_pkg::PH_DATA)
                     && !st_q.cmd[gdpsa_pkg::CMD_RD_BIT] && (cmd_addr == gdpsa_pkg::REG_LEVEL);

   // ----------------------------------------
   // register read decode
   // ----------------------------------------
   // unmapped addresses read as zero
   function automatic logic [7:0] reg_read(input logic [3:0] addr, input logic [7:0] func,
                                           input logic [7:0] dir, input logic [7:0] level,
                                           input logic [7:0] pins);
      logic [7:0] r;
      r = gdpsa_pkg::REG_RESET;
      if (addr == gdpsa_pkg::REG_FUNC) begin
         r = func;
      end else if (addr == gdpsa_pkg::REG_DIR) begin
         r = dir;
      end else if (addr == gdpsa_pkg::REG_LEVEL) begin
         r = (dir & pins) | (~dir & level);
      end
      return r;
   endfunction

   // ----------------------------------------
   // next-state logic
   // ----------------------------------------
   always_comb begin
      st_d           = st_q;
      st_d.sclk_prev = sclk_lvl;
      // port pins follow the stored bits; analog pins stay undriven
      st_d.pin_out   = st_q.level;
      st_d.pin_oe    = st_q.func & ~st_q.dir;
      if (!sel) begin
         // idle: frame state cleared, data out released
         st_d.phase   = gdpsa_pkg::PH_CMD;
         st_d.bitcnt  = 3'h0;
         st_d.miso    = 1'b0;
         st_d.miso_oe = 1'b0;
      end else begin
         st_d.miso_oe = 1'b1;
         // launch read data on rising edges only
         if (rise && st_q.phase == gdpsa_pkg::PH_DATA && st_q.cmd[gdpsa_pkg::CMD_RD_BIT]) begin
            st_d.miso = st_q.tx[7];
            st_d.tx   = {st_q.tx[6:0], 1'b0};
         end
         // capture on falling edges only
         if (fall) begin
            st_d.shift  = rx_byte;
            st_d.bitcnt = st_q.bitcnt + 3'h1;
         end
         if (byte_end) begin
            unique case (st_q.phase)
               gdpsa_pkg::PH_CMD: begin
                  // read data frozen here, first bit leaves on next rise
                  st_d.cmd   = rx_byte;
                  st_d.tx    = reg_read(rx_byte[gdpsa_pkg::CMD_ADDR_LO +: gdpsa_pkg::ADDR_W],
                                        st_q.func, st_q.dir, st_q.level, pin_lvl);
                  st_d.phase = gdpsa_pkg::PH_DATA;
               end
               gdpsa_pkg::PH_DATA: begin
                  if (!st_q.cmd[gdpsa_pkg::CMD_RD_BIT]) begin
                     // a write only stores; pin state comes from func, dir and level
                     if (cmd_addr == gdpsa_pkg::REG_FUNC) begin
                        st_d.func = rx_byte;
                     end else if (cmd_addr == gdpsa_pkg::REG_DIR) begin
                        st_d.dir = rx_byte;
                     end else if (cmd_addr == gdpsa_pkg::REG_LEVEL) begin
                        st_d.level = rx_byte;
                     end
                  end
                  st_d.phase = gdpsa_pkg::PH_DONE;
               end
               gdpsa_pkg::PH_DONE: begin
                  // extra bytes in a frame are ignored
                  st_d.phase = gdpsa_pkg::PH_DONE;
               end
               default: begin
                  st_d.phase = gdpsa_pkg::PH_CMD;
               end
            endcase
         end
      end
   end

   // register the whole state; everything clears to zero
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   // ----------------------------------------
   // outputs, straight from flops
   // ----------------------------------------
   assign miso    = st_q.miso;
   assign miso_oe = st_q.miso_oe;
   assign pin_out = st_q.pin_out;
   assign pin_oe  = st_q.pin_oe;

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   // helper: value that a read of the level register would load
   logic [7:0] rd_level_now;
   assign rd_level_now = (st_q.dir & pin_lvl) | (~st_q.dir & st_q.level);

   sequence s_write_level;
      wr_level;
   endsequence

   sequence s_cmd_read_level;
      byte_end && st_q.phase == gdpsa_pkg::PH_CMD && rx_byte[gdpsa_pkg::CMD_RD_BIT]
         && rx_byte[3:0] == gdpsa_pkg::REG_LEVEL;
   endsequence

   a_pin_drive_level : assert property (@(posedge ref_clk) disable iff (reset)
      1'b1 |=> pin_out == $past(st_q.level))
      else $error("pin output differs from stored level");

   a_pin_enable_func : assert property (@(posedge ref_clk) disable iff (reset)
      1'b1 |=> pin_oe == ($past(st_q.func) & ~$past(st_q.dir)))
      else $error("pin enable not function and output");

   a_reset_clear : assert property (@(posedge ref_clk)
      reset |=> (st_q.level == gdpsa_pkg::REG_RESET && st_q.func == gdpsa_pkg::REG_RESET
                 && st_q.dir == gdpsa_pkg::REG_RESET && pin_oe == gdpsa_pkg::REG_RESET))
      else $error("registers not cleared by reset");

   a_read_pin_live : assert property (@(posedge ref_clk) disable iff (reset)
      s_cmd_read_level |=> st_q.tx == $past(rd_level_now))
      else $error("level read did not return pin level");

   a_write_keeps_oe : assert property (@(posedge ref_clk) disable iff (reset)
      s_write_level |=> ##1 pin_oe == $past(pin_oe))
      else $error("level write changed pin enables");

   a_miso_on_rise : assert property (@(posedge ref_clk) disable iff (reset)
      $changed(miso) |-> ($past(rise) || !$past(sel)))
      else $error("data out changed off a rising edge");

   a_capture_fall : assert property (@(posedge ref_clk) disable iff (reset)
      $changed(st_q.shift) |-> $past(fall) && $past(sel))
      else $error("data captured off a falling edge");

   a_idle_release : assert property (@(posedge ref_clk) disable iff (reset)
      !sel |=> !miso_oe && !miso)
      else $error("data out driven outside a frame");

   a_level_offset : assert property (@(posedge ref_clk) disable iff (reset)
      s_write_level |=> st_q.level == $past(rx_byte))
      else $error("level write not stored");

endmodule

/* bench/gdpsa_host.sv */
`timescale 1ns/1ps
module gdpsa_host (
   // system clock
   input  wire logic ref_clk,
   // serial lines
   output logic      sclk,
   output logic      cs_n,
   output logic      mosi,
   input  wire logic miso
);
   // ----------------------------------------
   // idle state of the lines
   // ----------------------------------------
   initial begin
      sclk = 1'b0; // clock rests low
      cs_n = 1'b1;
      mosi = 1'b0;
   end

   // released data line flips every cycle so a stale bit never passes for data
   always @(negedge ref_clk) begin
      if (cs_n) begin
         mosi <= ~mosi;
      end
   end

   // ----------------------------------------
   // one frame, msb first, caller enters at a falling ref_clk edge
   // ----------------------------------------
   task automatic xfer(input logic [15:0] tx, input int nbits, output logic [7:0] rx);
      rx = 8'h00;
      cs_n = 1'b0;
      repeat (5) @(negedge ref_clk); // select settles before first rise
      for (int i = 0; i < nbits; i++) begin
         sclk = 1'b1;
         mosi = tx[15-i]; // data changes on rising edge
         repeat (4) @(negedge ref_clk);
         sclk = 1'b0; // both sides capture on this fall
         // host takes the read bit at the same falling edge
         if (i >= 8) begin
            rx = {rx[6:0], miso};
         end
         repeat (4) @(negedge ref_clk);
      end
      cs_n = 1'b1;
      repeat (8) @(negedge ref_clk); // gap lets the device drop miso_oe
   endtask
endmodule

/* bench/gdpsa_top_tb.sv */
`timescale 1ns/1ps
module gdpsa_top_tb;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   logic       ref_clk;
   logic       reset;
   logic       sclk;
   logic       cs_n;
   logic       mosi;
   logic       miso;
   logic       miso_oe;
   logic       miso_line; // data line as the host sees it
   logic [7:0] pin_in;
   logic [7:0] pin_out;
   logic [7:0] pin_oe;
   logic [7:0] ext_lvl;   // level forced by outside parts
   logic [7:0] rd;        // last read byte
   int         failures;
   int         n_tests;

   // wire level: device wins where it drives, else the outside level
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
   // undriven data line shows the inverse, so a missing enable spoils reads
   assign miso_line = miso_oe ? miso : ~miso;

   gdpsa_top dut_u (.ref_clk(ref_clk), .reset(reset), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
                    .miso(miso), .miso_oe(miso_oe), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
   gdpsa_host host_u (.ref_clk(ref_clk), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso_line));

   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
         failures++;
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      host_u.xfer({4'h0, a, d}, 16, rd);
   endtask

   task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
      host_u.xfer({4'h8, a, 8'h00}, 16, rd);
      chk8(rd, exp);
   endtask

   task automatic close_out;
      if (failures == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // hang guard
   initial begin
      repeat (20000) @(posedge ref_clk);
      failures++;
      close_out();
   end

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      failures = 0;
      n_tests = 0;
      reset = 1'b1;
      ext_lvl = 8'h3C;
      repeat (5) @(negedge ref_clk);
      reset = 1'b0;
      repeat (gdpsa_pkg::POR_MCLK_CYCLES) @(negedge ref_clk);
      chk8(pin_out, 8'h00);
      chk8(pin_oe, 8'h00);
      rd_chk(gdpsa_pkg::REG_FUNC, 8'h00);
      rd_chk(gdpsa_pkg::REG_DIR, 8'h00);
      rd_chk(gdpsa_pkg::REG_LEVEL, 8'h00);
      // analog pins keep their function even with stored ones
      wr(gdpsa_pkg::REG_LEVEL, 8'hA5);
      chk8(pin_oe, 8'h00);
      rd_chk(4'hE, 8'hA5);
      wr(gdpsa_pkg::REG_FUNC, 8'hFF);
      chk8(pin_oe, 8'hFF);
      // walking one shows each bit on its own pin
      for (int i = 0; i < 8; i++) begin
         wr(gdpsa_pkg::REG_LEVEL, 8'h01 << i);
         chk8(pin_out, 8'h01 << i);
         chk8(pin_in, 8'h01 << i);
      end
      // low nibble turned to inputs
      wr(gdpsa_pkg::REG_DIR, 8'h0F);
      chk8(pin_oe, 8'hF0);
      wr(gdpsa_pkg::REG_LEVEL, 8'h5A);
      rd_chk(gdpsa_pkg::REG_LEVEL, 8'h5C);
      chk8(pin_in, 8'h5C);
      ext_lvl = 8'hC3;
      rd_chk(gdpsa_pkg::REG_LEVEL, 8'h53);
      // stored bits survive the input spell
      wr(gdpsa_pkg::REG_DIR, 8'h00);
      rd_chk(gdpsa_pkg::REG_LEVEL, 8'h5A);
      // unmapped place reads zero and drops writes
      wr(4'h3, 8'hFF);
      rd_chk(4'h3, 8'h00);
      rd_chk(gdpsa_pkg::REG_LEVEL, 8'h5A);
      // frame cut after the command byte
      host_u.xfer({4'h0, gdpsa_pkg::REG_LEVEL, 8'h00}, 8, rd);
      rd_chk(gdpsa_pkg::REG_LEVEL, 8'h5A);
      rd_chk(gdpsa_pkg::REG_DIR, 8'h00);
      rd_chk(gdpsa_pkg::REG_FUNC, 8'hFF);
      chk8({7'h00, miso_oe}, 8'h00);
      // reset in mid-run clears everything
      reset = 1'b1;
      @(negedge ref_clk);
      reset = 1'b0;
      chk8(pin_out, 8'h00);
      chk8(pin_oe, 8'h00);
      repeat (5) @(negedge ref_clk);
      rd_chk(gdpsa_pkg::REG_LEVEL, 8'h00);
      close_out();
   end
endmodule
